//--- rtl/aide_params.svh
// Purpose: Offsets, field positions, reset values and counts of the aux input debounce block.
// Assumes: Included by its bare name wherever the register map is needed.
// Notes: Definitions only.
`ifndef AIDE_PARAMS_SVH
`define AIDE_PARAMS_SVH

// ****************************************
// Register offsets.
// ****************************************
`define AIDE_ADDR_CTRL 8'h00
`define AIDE_ADDR_LOOP_DIV 8'h04
`define AIDE_ADDR_DEBOUNCE 8'h08
`define AIDE_ADDR_STATE 8'h0C
`define AIDE_ADDR_IRQ_STATUS 8'h10
`define AIDE_ADDR_IRQ_MASK 8'h14

// ****************************************
// Field positions and widths.
// ****************************************
`define AIDE_CTRL_RUN_BIT 0
`define AIDE_LEN_W 4
`define AIDE_PINS 4
`define AIDE_DIV_W 16
`define AIDE_STATE_RAW_LSB 0
`define AIDE_STATE_FILT_LSB 4
`define AIDE_STATE_RISE_LSB 8
`define AIDE_STATE_FALL_LSB 12
`define AIDE_STATE_HIGH_LSB 16
`define AIDE_STATE_LOW_LSB 20
`define AIDE_IRQ_FALL_LSB 4

// ****************************************
// Reset values.
// ****************************************
`define AIDE_CTRL_RESET 1'h1
`define AIDE_LOOP_DIV_RESET 16'h0027
`define AIDE_DEBOUNCE_RESET 16'h0000
`define AIDE_IRQ_MASK_RESET 8'h00

`endif

//--- rtl/aide_pkg.sv
// Purpose: State types of the aux input debounce and edge detect block.
// Assumes: Widths match the constants header.
// Notes: Types only.
package aide_pkg;

	// ****************************************
	// State of one pin filter.
	// ****************************************
	typedef struct packed {
		logic [3:0] cnt;
		logic filt;
		logic rise;
		logic fall;
		logic high;
		logic low;
	} aide_filt_t;

	// ****************************************
	// State of the top level.
	// ****************************************
	typedef struct packed {
		logic run;
		logic [15:0] div_cnt;
		logic [15:0] loop_div;
		logic tick;
		logic tick_d;
		logic [15:0] debounce;
		logic [7:0] irq_status;
		logic [7:0] irq_mask;
		logic [31:0] rdata;
	} aide_top_t;

endpackage

//--- rtl/aide_filter.sv
// Purpose: Debounce filter and edge and level decoder for one auxiliary input.
// Assumes: tick is a one-cycle pulse once per loop resolution period.
// Notes: All outputs change only on the clock edge after a tick.
`timescale 1ns/100ps
`include "aide_params.svh"

module aide_filter (
	input wire logic clock,
	input wire logic rstn,
	input wire logic tick,
	input wire logic level_in,
	input wire logic [3:0] length,
	output logic filtered,
	output logic rise,
	output logic fall,
	output logic high,
	output logic low
);

	aide_pkg::aide_filt_t s;
	aide_pkg::aide_filt_t next_s;

	// ****************************************
	// Filter and decoder.
	// ****************************************
	always_comb begin
		next_s = s;
		if (tick) begin
			if (level_in != s.filt) begin
				if (s.cnt >= length) begin
					next_s.filt = level_in;
					next_s.cnt = 4'h0;
				end else begin
					next_s.cnt = s.cnt + 4'h1;
				end
			end else begin
				next_s.cnt = 4'h0;
			end
			next_s.rise = next_s.filt && !s.filt;
			next_s.fall = !next_s.filt && s.filt;
			next_s.high = next_s.filt && !next_s.rise;
			next_s.low = !next_s.filt && !next_s.fall;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign filtered = s.filt;
	assign rise = s.rise;
	assign fall = s.fall;
	assign high = s.high;
	assign low = s.low;

	// ****************************************
	// Checks.
	// ****************************************
	short_phase_a: assert property (@(posedge clock) disable iff (!rstn)
		tick && level_in != s.filt && s.cnt < length |=> s.filt == $past(s.filt))
		else $error("Filtered level changed before the debounce length ran out.");
	long_phase_a: assert property (@(posedge clock) disable iff (!rstn)
		tick && level_in != s.filt && s.cnt >= length |=> s.filt == $past(level_in))
		else $error("Filtered level did not follow a long enough phase.");
	edge_level_a: assert property (@(posedge clock) disable iff (!rstn)
		(s.rise |-> !s.high && s.filt) and (s.fall |-> !s.low && !s.filt))
		else $error("Level flag asserted together with its edge.");
	rise_seen_a: assert property (@(posedge clock) disable iff (!rstn)
		$rose(s.filt) |-> s.rise && $past(tick))
		else $error("Filtered rise without a rise flag.");
	edge_once_a: assert property (@(posedge clock) disable iff (!rstn)
		tick && s.rise && level_in == s.filt |=> !s.rise && s.high)
		else $error("Rise flag held longer than one loop period.");
	quiet_hold_a: assert property (@(posedge clock) disable iff (!rstn)
		!tick |=> $stable(s))
		else $error("Filter state moved without a loop tick.");

endmodule // aide_filter

//--- rtl/aide_top.sv
// Purpose: Debounce and edge and level detect for four auxiliary counter inputs.
// Assumes: Inputs are synchronous to clock; plain register port, read data one cycle later.
// Notes: One loop tick every loop_div plus one clocks while run is set.
//
// Function
// - Each pin has its own debounce length.
// - Phases not longer than length are suppressed.
// - Phase one period longer than length passes.
// - Filter delay grows with debounce length.
// - Decode rise, fall, high and low per pin.
// - Level flags off in the edge period.
// - Blocked lows give one rise, then high.
`timescale 1ns/100ps
`include "aide_params.svh"

module aide_top (
	input wire logic clock,
	input wire logic rstn,
	input wire logic aux_input_w,
	input wire logic aux_input_x,
	input wire logic aux_input_y,
	input wire logic aux_input_z,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_strobe,
	input wire logic rd_strobe,
	output logic [31:0] rdata,
	output logic [3:0] aux_filtered,
	output logic [3:0] aux_rise,
	output logic [3:0] aux_fall,
	output logic [3:0] aux_high,
	output logic [3:0] aux_low,
	output logic loop_tick,
	output logic irq
);

	// ****************************************
	// Helpers.
	// ****************************************
	function automatic logic [3:0] aide_len(input logic [15:0] deb, input int idx);
		aide_len = deb[idx * `AIDE_LEN_W +: `AIDE_LEN_W];
	endfunction

	function automatic logic aide_hit(input logic [7:0] a, input logic [7:0] target);
		aide_hit = (a == target);
	endfunction

	aide_pkg::aide_top_t s;
	aide_pkg::aide_top_t next_s;
	logic [3:0] raw;
	logic [3:0] filt_v;
	logic [3:0] rise_v;
	logic [3:0] fall_v;
	logic [3:0] high_v;
	logic [3:0] low_v;
	logic [7:0] irq_set;
	logic [7:0] irq_clear;

	assign raw = {aux_input_z, aux_input_y, aux_input_x, aux_input_w};

	// ****************************************
	// Pin filters.
	// ****************************************
	for (genvar i = 0; i < `AIDE_PINS; i++) begin : g_pin
		aide_filter aide_filter_inst (
			.clock(clock),
			.rstn(rstn),
			.tick(s.tick),
			.level_in(raw[i]),
			.length(aide_len(s.debounce, i)),
			.filtered(filt_v[i]),
			.rise(rise_v[i]),
			.fall(fall_v[i]),
			.high(high_v[i]),
			.low(low_v[i])
		);
	end

	// ****************************************
	// Interrupt events.
	// ****************************************
	assign irq_set = s.tick_d ? {fall_v, rise_v} : 8'h00;
	assign irq_clear = (wr_strobe && aide_hit(addr, `AIDE_ADDR_IRQ_STATUS)) ? wdata[7:0] : 8'h00;

	// ****************************************
	// Next state.
	// ****************************************
	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		next_s.tick_d = s.tick;
		if (s.run) begin
			if (s.div_cnt == 16'h0000) begin
				next_s.div_cnt = s.loop_div;
				next_s.tick = 1'b1;
			end else begin
				next_s.div_cnt = s.div_cnt - 16'h0001;
			end
		end
		next_s.irq_status = (s.irq_status & ~irq_clear) | irq_set;
		if (wr_strobe) begin
			unique case (addr)
				`AIDE_ADDR_CTRL: begin
					next_s.run = wdata[`AIDE_CTRL_RUN_BIT];
				end
				`AIDE_ADDR_LOOP_DIV: begin
					next_s.loop_div = wdata[15:0];
				end
				`AIDE_ADDR_DEBOUNCE: begin
					next_s.debounce = wdata[15:0];
				end
				`AIDE_ADDR_IRQ_MASK: begin
					next_s.irq_mask = wdata[7:0];
				end
				default: begin
				end
			endcase
		end
		next_s.rdata = 32'h0000_0000;
		if (rd_strobe) begin
			unique case (addr)
				`AIDE_ADDR_CTRL: begin
					next_s.rdata = {31'h0000_0000, s.run};
				end
				`AIDE_ADDR_LOOP_DIV: begin
					next_s.rdata = {16'h0000, s.loop_div};
				end
				`AIDE_ADDR_DEBOUNCE: begin
					next_s.rdata = {16'h0000, s.debounce};
				end
				`AIDE_ADDR_STATE: begin
					next_s.rdata = {8'h00, low_v, high_v, fall_v, rise_v, filt_v, raw};
				end
				`AIDE_ADDR_IRQ_STATUS: begin
					next_s.rdata = {24'h00_0000, s.irq_status};
				end
				`AIDE_ADDR_IRQ_MASK: begin
					next_s.rdata = {24'h00_0000, s.irq_mask};
				end
				default: begin
					next_s.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// ****************************************
	// State register.
	// ****************************************
	always_ff @(posedge clock) begin
		if (!rstn) begin
			s.run <= `AIDE_CTRL_RESET;
			s.div_cnt <= `AIDE_LOOP_DIV_RESET;
			s.loop_div <= `AIDE_LOOP_DIV_RESET;
			s.tick <= 1'b0;
			s.tick_d <= 1'b0;
			s.debounce <= `AIDE_DEBOUNCE_RESET;
			s.irq_status <= 8'h00;
			s.irq_mask <= `AIDE_IRQ_MASK_RESET;
			s.rdata <= 32'h0000_0000;
		end else begin
			s <= next_s;
		end
	end

	// ****************************************
	// Outputs.
	// ****************************************
	assign rdata = s.rdata;
	assign aux_filtered = filt_v;
	assign aux_rise = rise_v;
	assign aux_fall = fall_v;
	assign aux_high = high_v;
	assign aux_low = low_v;
	assign loop_tick = s.tick;
	assign irq = |(s.irq_status & s.irq_mask);

	// ****************************************
	// Checks.
	// ****************************************
	status_set_a: assert property (@(posedge clock) disable iff (!rstn)
		s.tick_d && rise_v[0] |=> s.irq_status[0])
		else $error("Rise event on pin w did not set its status bit.");
	set_wins_a: assert property (@(posedge clock) disable iff (!rstn)
		s.tick_d && fall_v[3] && irq_clear[7] |=> s.irq_status[7])
		else $error("Clear overrode a simultaneous event.");
	length_reach_a: assert property (@(posedge clock) disable iff (!rstn)
		wr_strobe && aide_hit(addr, `AIDE_ADDR_DEBOUNCE) |=>
		g_pin[3].aide_filter_inst.length == $past(wdata[15:12]))
		else $error("Debounce length of pin z not steered by the register.");
	level_excl_a: assert property (@(posedge clock) disable iff (!rstn)
		(aux_rise & aux_high) == 4'h0 && (aux_fall & aux_low) == 4'h0)
		else $error("Level flag shown in the edge period.");
	read_once_a: assert property (@(posedge clock) disable iff (!rstn)
		!rd_strobe |=> rdata == 32'h0000_0000)
		else $error("Read data outside the answer cycle.");

endmodule // aide_top

//--- tb/aide_aux_source.sv
// Purpose: Model of the four external aux input signals.
// Assumes: Pins change just after a loop tick edge.
// Notes: All pins carry one pattern, 5 periods high then 4 low.
`timescale 1ns/100ps

module aide_aux_source (
	input wire logic clock,
	input wire logic rstn,
	input wire logic loop_tick,
	input wire logic enable,
	output logic [3:0] pins
);
	// ****************************************
	// Pattern generator.
	// ****************************************
	int phase;
	always @(posedge clock) begin
		if (!rstn || !enable) begin
			phase <= 0;
			pins <= 4'h0;
		end else if (loop_tick) begin
			pins <= (phase < 5) ? 4'hF : 4'h0;
			phase <= (phase == 8) ? 0 : phase + 1;
		end
	end
endmodule // aide_aux_source

//--- tb/aux_input_debounce_edge_detect_bench.sv
// Purpose: Self-checking bench of the aux input debounce block.
// Assumes: Loop period shortened to 4 clocks.
// Notes: Flags are sampled on the falling clock edge.
`timescale 1ns/100ps
`include "aide_params.svh"

module aux_input_debounce_edge_detect_bench;
	logic clock = 1'b0, rstn = 1'b0, wr_strobe = 1'b0, rd_strobe = 1'b0, src_en = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic [3:0] pins, filt, rise, fall, high, low;
	logic loop_tick, irq;
	logic [3:0] prev_r = 4'h0, prev_f = 4'h0;
	int num_errors = 0, total_checks = 0, cycles = 0, ticks = 0;
	int rise_cnt[4], fall_cnt[4], first[4];

	aide_aux_source aide_aux_source_inst (.clock(clock), .rstn(rstn), .loop_tick(loop_tick),
		.enable(src_en), .pins(pins));
	aide_top aide_top_inst (.clock(clock), .rstn(rstn), .aux_input_w(pins[0]),
		.aux_input_x(pins[1]), .aux_input_y(pins[2]), .aux_input_z(pins[3]), .addr(addr),
		.wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
		.aux_filtered(filt), .aux_rise(rise), .aux_fall(fall), .aux_high(high),
		.aux_low(low), .loop_tick(loop_tick), .irq(irq));

	// ****************************************
	// Support tasks.
	// ****************************************
	initial begin
		forever #12.5 clock = ~clock;
	end

	task stop_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr_strobe <= 1'b1;
		@(posedge clock);
		wr_strobe <= 1'b0;
	endtask

	task rd_check(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		addr <= a;
		rd_strobe <= 1'b1;
		@(posedge clock);
		rd_strobe <= 1'b0;
		#1 check(rdata, exp);
	endtask

	task clear;
		ticks = 0;
		foreach (first[i]) begin
			rise_cnt[i] = 0;
			fall_cnt[i] = 0;
			first[i] = -1;
		end
	endtask

	task reset_dut;
		@(posedge clock);
		rstn <= 1'b0;
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		clear;
	endtask

	task run_ticks(input int n);
		repeat (n) begin
			@(negedge clock);
			while (loop_tick !== 1'b1) @(negedge clock);
		end
	endtask

	// ****************************************
	// Monitor and timeout.
	// ****************************************
	always @(negedge clock) begin
		if (rstn === 1'b1) begin
			if (loop_tick === 1'b1) ticks++;
			foreach (first[i]) begin
				if (rise[i] === 1'b1 && prev_r[i] !== 1'b1) begin
					rise_cnt[i]++;
					if (first[i] < 0) first[i] = ticks;
				end
				if (fall[i] === 1'b1 && prev_f[i] !== 1'b1) fall_cnt[i]++;
			end
			prev_r = rise;
			prev_f = fall;
			if (ticks > 1) check({high, low}, {filt & ~rise, ~filt & ~fall});
		end
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			stop_test;
		end
	end

	// ****************************************
	// Scenarios.
	// ****************************************
	task test_regs;
		reset_dut;
		rd_check(`AIDE_ADDR_DEBOUNCE, 32'h0000_0000);
		rd_check(`AIDE_ADDR_LOOP_DIV, 32'h0000_0027);
		rd_check(`AIDE_ADDR_IRQ_MASK, 32'h0000_0000);
		rd_check(8'h40, 32'h0000_0000);
		rd_check(`AIDE_ADDR_CTRL, 32'h0000_0001);
		wr(`AIDE_ADDR_CTRL, 32'h0000_0000);
		rd_check(`AIDE_ADDR_CTRL, 32'h0000_0000);
		ticks = 0;
		repeat (60) @(posedge clock);
		check(32'(ticks), 32'h0000_0000);
		wr(`AIDE_ADDR_CTRL, 32'h0000_0001);
		wr(`AIDE_ADDR_DEBOUNCE, 32'h0000_5432);
		rd_check(`AIDE_ADDR_DEBOUNCE, 32'h0000_5432);
		$display("test_regs done");
	endtask

	task test_pass;
		reset_dut;
		wr(`AIDE_ADDR_LOOP_DIV, 32'h0000_0003);
		wr(`AIDE_ADDR_DEBOUNCE, 32'h0000_0123);
		clear;
		@(posedge clock) src_en <= 1'b1;
		run_ticks(90);
		@(posedge clock) src_en <= 1'b0;
		run_ticks(10);
		foreach (first[i]) begin
			check(32'(rise_cnt[i]), 32'h0000_000A);
			check(32'(fall_cnt[i]), 32'h0000_000A);
			check(32'(first[i]), 32'(first[3] + 3 - i));
		end
		$display("test_pass done");
	endtask

	task test_irq;
		rd_check(`AIDE_ADDR_IRQ_STATUS, 32'h0000_00FF);
		check({31'h0, irq}, 32'h0000_0000);
		wr(`AIDE_ADDR_IRQ_MASK, 32'h0000_0010);
		@(negedge clock) check({31'h0, irq}, 32'h0000_0001);
		wr(`AIDE_ADDR_IRQ_STATUS, 32'h0000_0010);
		@(negedge clock) check({31'h0, irq}, 32'h0000_0000);
		rd_check(`AIDE_ADDR_IRQ_STATUS, 32'h0000_00EF);
		$display("test_irq done");
	endtask

	task test_block;
		reset_dut;
		wr(`AIDE_ADDR_LOOP_DIV, 32'h0000_0003);
		wr(`AIDE_ADDR_DEBOUNCE, 32'h0000_2345);
		clear;
		@(posedge clock) src_en <= 1'b1;
		run_ticks(90);
		check(32'(rise_cnt[0]), 32'h0000_0000);
		check(32'(rise_cnt[1]), 32'h0000_0001);
		check(32'(fall_cnt[1]), 32'h0000_0000);
		check({31'h0, high[1]}, 32'h0000_0001);
		check(32'(rise_cnt[2]), 32'h0000_000A);
		check(32'(rise_cnt[3]), 32'h0000_000A);
		@(posedge clock) src_en <= 1'b0;
		$display("test_block done");
	endtask

	initial begin
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		test_regs;
		test_pass;
		test_irq;
		test_block;
		stop_test;
	end
endmodule // aux_input_debounce_edge_detect_bench
